// ---- shared/srt_map.svh ----
`ifndef SRT_MAP_SVH
`define SRT_MAP_SVH

// ****************************************
// Clock and timing
// ****************************************
`define SRT_CLK_PERIOD_NS     100
// Longest time from suspend request to halt, in ns
`define SRT_SUSP_LAT_NS       20000
// Least time from resume to the next suspend, in ns
`define SRT_RES2SUS_NS        128000
// Longest halt time rounds down, least interval rounds up
`define SRT_SUSP_LAT_CYC      (`SRT_SUSP_LAT_NS / `SRT_CLK_PERIOD_NS)
`define SRT_RES2SUS_CYC       ((`SRT_RES2SUS_NS + `SRT_CLK_PERIOD_NS - 1) / `SRT_CLK_PERIOD_NS)
// Typical sector erase and page program times, in ns
`define SRT_ERASE_NS          45000000
`define SRT_PROG_NS           500000
`define SRT_ERASE_CYC         (`SRT_ERASE_NS / `SRT_CLK_PERIOD_NS)
`define SRT_PROG_CYC          (`SRT_PROG_NS / `SRT_CLK_PERIOD_NS)

// ****************************************
// Latency unit codes
// ****************************************
`define SRT_UNIT_128NS        2'b00
`define SRT_UNIT_1US          2'b01
`define SRT_UNIT_8US          2'b10
`define SRT_UNIT_64US         2'b11

// ****************************************
// Suspend parameter word fields
// ****************************************
`define SRT_F_SUPPORTED       1'b0
`define SRT_F_ERS_LAT_UNIT    `SRT_UNIT_1US
`define SRT_F_ERS_LAT_CNT     5'b1_0011
`define SRT_F_ERS_INTERVAL    4'b0001
`define SRT_F_PRG_LAT_UNIT    `SRT_UNIT_1US
`define SRT_F_PRG_LAT_CNT     5'b1_0011
`define SRT_F_PRG_INTERVAL    4'b0001
`define SRT_F_RFU             1'b1
`define SRT_F_ERS_PROHIBIT    4'b1110
`define SRT_F_PRG_PROHIBIT    4'b1101

// ****************************************
// Address geometry
// ****************************************
`define SRT_ADDR_W            24
`define SRT_SECTOR_LSB        12
`define SRT_PAGE_LSB          8
`define SRT_CNT_W             20
`define SRT_GUARD_W           12

`endif

// ---- shared/srt_pkg.sv ----
`include "srt_map.svh"

package srt_pkg;

    typedef enum logic [2:0] {
        SRT_OP_NONE    = 3'h0,
        SRT_OP_READ    = 3'h1,
        SRT_OP_PROG    = 3'h2,
        SRT_OP_ERASE   = 3'h3,
        SRT_OP_SUSPEND = 3'h4,
        SRT_OP_RESUME  = 3'h5
    } srt_op_t;

    typedef enum logic [2:0] {
        SRT_D_IDLE  = 3'h0,
        SRT_D_ERASE = 3'h1,
        SRT_D_PROG  = 3'h2,
        SRT_D_ESUSP = 3'h3,
        SRT_D_PSUSP = 3'h4
    } srt_dstate_t;

    typedef enum logic [1:0] {
        SRT_H_IDLE = 2'h0,
        SRT_H_SEND = 2'h1,
        SRT_H_WAIT = 2'h2
    } srt_hstate_t;

    typedef logic [`SRT_ADDR_W-1:0] srt_addr_t;

endpackage : srt_pkg

// ---- shared/srt_link_if.sv ----
`timescale 1ns/1ps

interface srt_link_if
    import srt_pkg::*;
();
    logic        req;
    srt_op_t     op;
    srt_addr_t   addr;
    logic        ack;
    logic        nack;
    logic        busy;
    logic        esusp;
    logic        psusp;
    logic [31:0] param;

    modport dev (
        input  req,
        input  op,
        input  addr,
        output ack,
        output nack,
        output busy,
        output esusp,
        output psusp,
        output param
    );

    modport host (
        output req,
        output op,
        output addr,
        input  ack,
        input  nack,
        input  busy,
        input  esusp,
        input  psusp,
        input  param
    );

endinterface : srt_link_if

// ---- rtl/srt_dev.sv ----
`timescale 1ns/1ps
`include "srt_map.svh"

// Behaviour
// [R1] Word bit 31 zero: suspend supported
// [R2] Latency units: 128ns, 1us, 8us, 64us
// [R3] Erase halts within 20 us
// [R4] Host waits 128 us resume-to-suspend after erase
// [R5] Program halts within 20 us
// [R6] Host waits 128 us resume-to-suspend after program
// [R7] No new erase while erase suspended
// [R8] No read of suspended erase sector
// [R9] No new program while program suspended
// [R10] No erase over suspended program page
// [R11] Prohibition fields read 1110b and 1101b
// [R12] Resume only acted on while suspended

module srt_dev
    import srt_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = `SRT_ERASE_CYC,
    parameter int unsigned PROG_CYCLES  = `SRT_PROG_CYC,
    parameter int unsigned HALT_CYCLES  = 1
) (
    input  wire logic  clk_in,
    input  wire logic  rstn_in,
    srt_link_if.dev    link,
    output logic       op_done_out,
    output srt_addr_t  op_addr_out
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        srt_dstate_t             st;
        logic [`SRT_CNT_W-1:0]   cnt;
        logic [`SRT_CNT_W-1:0]   halt;
        logic                    halting;
        srt_addr_t               addr;
        logic                    ack;
        logic                    nack;
        logic                    busy;
        logic                    esusp;
        logic                    psusp;
        logic                    done;
        logic [31:0]             param;
    } srt_dev_s_t;

    srt_dev_s_t s_q;
    srt_dev_s_t s_d;

    // ****************************************
    // Parameter word
    // ****************************************
    // Registered, so the word reads zero while reset is held
    function automatic logic [31:0] param_word();
        return {`SRT_F_SUPPORTED,                               // [R1]
                `SRT_F_ERS_LAT_UNIT,                            // [R2]
                `SRT_F_ERS_LAT_CNT,                             // [R3]
                `SRT_F_ERS_INTERVAL,
                `SRT_F_PRG_LAT_UNIT,                            // [R2]
                `SRT_F_PRG_LAT_CNT,                             // [R5]
                `SRT_F_PRG_INTERVAL,
                `SRT_F_RFU,
                `SRT_F_ERS_PROHIBIT,                            // [R11]
                `SRT_F_PRG_PROHIBIT};                           // [R11]
    endfunction : param_word

    // Halt delay is capped so the reported latency always holds;
    // one cycle of the budget goes to the registered answer
    localparam int unsigned HALT_LIM = `SRT_SUSP_LAT_CYC - 1;
    localparam int unsigned HALT_CAP = (HALT_CYCLES < HALT_LIM) ? HALT_CYCLES : HALT_LIM;
    localparam logic [`SRT_CNT_W-1:0] HALT_LOAD = (HALT_CAP > 1) ? `SRT_CNT_W'(HALT_CAP - 1) : '0;

    function automatic logic is_suspended(input srt_dstate_t st);
        return (st == SRT_D_ESUSP) || (st == SRT_D_PSUSP);
    endfunction : is_suspended

    function automatic logic is_running(input srt_dstate_t st);
        return (st == SRT_D_ERASE) || (st == SRT_D_PROG);
    endfunction : is_running

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d       = s_q;
        s_d.ack   = 1'b0;
        s_d.nack  = 1'b0;
        s_d.done  = 1'b0;
        s_d.param = param_word();
        case (s_q.st)
            SRT_D_IDLE: begin
                if (link.req) begin
                    case (link.op)
                        SRT_OP_READ: begin
                            s_d.ack = 1'b1;
                        end
                        SRT_OP_ERASE: begin
                            s_d.ack  = 1'b1;
                            s_d.addr = link.addr;
                            s_d.cnt  = `SRT_CNT_W'(ERASE_CYCLES);
                            s_d.st   = SRT_D_ERASE;
                        end
                        SRT_OP_PROG: begin
                            s_d.ack  = 1'b1;
                            s_d.addr = link.addr;
                            s_d.cnt  = `SRT_CNT_W'(PROG_CYCLES);
                            s_d.st   = SRT_D_PROG;
                        end
                        default: begin
                            // Suspend or resume with nothing in flight
                            s_d.nack = 1'b1;                    // [R12]
                        end
                    endcase
                end
            end
            SRT_D_ERASE,
            SRT_D_PROG: begin
                if (s_q.halting) begin
                    // The operation is frozen while the array settles;
                    // requests here go unanswered, the host is still waiting
                    if (s_q.halt == '0) begin
                        s_d.halting = 1'b0;
                        s_d.ack     = 1'b1;
                        s_d.st      = (s_q.st == SRT_D_ERASE) ? SRT_D_ESUSP : SRT_D_PSUSP;  // [R3] [R5]
                    end else begin
                        s_d.halt = s_q.halt - 1'b1;
                    end
                end else if (s_q.cnt <= `SRT_CNT_W'(1)) begin
                    // Completion wins over a suspend in the same cycle
                    s_d.cnt  = '0;
                    s_d.done = 1'b1;
                    s_d.st   = SRT_D_IDLE;
                    if (link.req) begin
                        s_d.nack = 1'b1;
                    end
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                    if (link.req) begin
                        if (link.op == SRT_OP_SUSPEND) begin
                            s_d.halting = 1'b1;
                            s_d.halt    = HALT_LOAD;            // [R3] [R5]
                        end else begin
                            s_d.nack = 1'b1;
                        end
                    end
                end
            end
            SRT_D_ESUSP,
            SRT_D_PSUSP: begin
                // Reads of the suspended erase sector are screened by the host
                if (link.req) begin
                    case (link.op)
                        SRT_OP_READ: begin
                            s_d.ack = 1'b1;
                        end
                        SRT_OP_RESUME: begin
                            if (is_suspended(s_q.st)) begin     // [R12]
                                s_d.ack = 1'b1;
                                s_d.st  = (s_q.st == SRT_D_ESUSP) ? SRT_D_ERASE : SRT_D_PROG;
                            end else begin
                                s_d.nack = 1'b1;                // [R12]
                            end
                        end
                        default: begin
                            // Nesting is refused here, including the program, suspend and other-sector erase the host passes
                            s_d.nack = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                s_d.st = SRT_D_IDLE;
            end
        endcase
        s_d.busy  = is_running(s_d.st);
        s_d.esusp = (s_d.st == SRT_D_ESUSP);
        s_d.psusp = (s_d.st == SRT_D_PSUSP);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q         <= '0;
            s_q.st      <= SRT_D_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Every output is a register bit, so the host never sees a glitch
    assign link.ack     = s_q.ack;
    assign link.nack    = s_q.nack;
    assign link.busy    = s_q.busy;
    assign link.esusp   = s_q.esusp;
    assign link.psusp   = s_q.psusp;
    assign link.param   = s_q.param;
    assign op_done_out  = s_q.done;
    assign op_addr_out  = s_q.addr;

endmodule : srt_dev

// ---- rtl/srt_host.sv ----
`timescale 1ns/1ps
`include "srt_map.svh"

module srt_host
    import srt_pkg::*;
(
    input  wire logic     clk_in,
    input  wire logic     rstn_in,
    input  wire logic     req_valid_in,
    input  wire srt_op_t  req_op_in,
    input  wire srt_addr_t req_addr_in,
    output logic          req_ready_out,
    output logic          done_out,
    output logic          refused_out,
    srt_link_if.host      link
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        srt_hstate_t               st;
        srt_op_t                   op;
        srt_addr_t                 addr;
        srt_addr_t                 ers_addr;
        srt_addr_t                 prg_addr;
        logic [`SRT_GUARD_W-1:0]   guard;
        logic                      req;
        logic                      ready;
        logic                      done;
        logic                      refused;
    } srt_host_s_t;

    srt_host_s_t s_q;
    srt_host_s_t s_d;

    function automatic logic same_unit(input srt_addr_t a, input srt_addr_t b, input int unsigned lsb);
        return (a >> lsb) == (b >> lsb);
    endfunction : same_unit

    // ****************************************
    // Local checks on a new request
    // ****************************************
    logic blocked;

    always_comb begin
        blocked = 1'b0;
        case (req_op_in)
            SRT_OP_SUSPEND: begin
                blocked = (s_q.guard != '0);                                        // [R4] [R6]
            end
            SRT_OP_ERASE: begin
                blocked = link.esusp                                                // [R7]
                        | (link.psusp & same_unit(req_addr_in, s_q.prg_addr, `SRT_SECTOR_LSB));  // [R10]
            end
            SRT_OP_READ: begin
                blocked = link.esusp & same_unit(req_addr_in, s_q.ers_addr, `SRT_SECTOR_LSB);    // [R8]
            end
            SRT_OP_PROG: begin
                blocked = link.psusp;                                               // [R9]
            end
            default: begin
                blocked = (req_op_in == SRT_OP_NONE);
            end
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d         = s_q;
        s_d.done    = 1'b0;
        s_d.refused = 1'b0;
        if (s_q.guard != '0) begin
            s_d.guard = s_q.guard - 1'b1;
        end
        case (s_q.st)
            SRT_H_IDLE: begin
                if (req_valid_in) begin
                    s_d.ready = 1'b0;
                    if (blocked) begin
                        s_d.refused = 1'b1;
                        s_d.st      = SRT_H_SEND;
                    end else begin
                        s_d.op   = req_op_in;
                        s_d.addr = req_addr_in;
                        s_d.req  = 1'b1;
                        s_d.st   = SRT_H_WAIT;
                    end
                end
            end
            SRT_H_SEND: begin
                // One idle cycle keeps ready low after a refusal
                s_d.ready = 1'b1;
                s_d.st    = SRT_H_IDLE;
            end
            SRT_H_WAIT: begin
                s_d.req = 1'b0;
                if (link.ack) begin
                    s_d.done  = 1'b1;
                    s_d.ready = 1'b1;
                    s_d.st    = SRT_H_IDLE;
                    if (s_q.op == SRT_OP_ERASE) begin
                        s_d.ers_addr = s_q.addr;
                    end
                    if (s_q.op == SRT_OP_PROG) begin
                        s_d.prg_addr = s_q.addr;
                    end
                    if (s_q.op == SRT_OP_RESUME) begin
                        s_d.guard = `SRT_GUARD_W'(`SRT_RES2SUS_CYC);                // [R4] [R6]
                    end
                end else if (link.nack) begin
                    s_d.refused = 1'b1;
                    s_d.ready   = 1'b1;
                    s_d.st      = SRT_H_IDLE;
                end
            end
            default: begin
                s_d.st = SRT_H_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q       <= '0;
            s_q.st    <= SRT_H_IDLE;
            s_q.op    <= SRT_OP_NONE;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready_out = s_q.ready;
    assign done_out      = s_q.done;
    assign refused_out   = s_q.refused;
    assign link.req      = s_q.req;
    assign link.op       = s_q.op;
    assign link.addr     = s_q.addr;

endmodule : srt_host

// ---- verification/srt_link_sva.sv ----
`timescale 1ns/1ps
`include "srt_map.svh"

module srt_link_sva
    import srt_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic        req,
    input wire srt_op_t     op,
    input wire srt_addr_t   addr,
    input wire logic        ack,
    input wire logic        nack,
    input wire logic        busy,
    input wire logic        esusp,
    input wire logic        psusp,
    input wire logic [31:0] param
);
    localparam int HALT_MAX = `SRT_SUSP_LAT_CYC;
    // Two cycles of slack: the guard is counted by the host from its own view of ack
    localparam int GUARD_MIN = `SRT_RES2SUS_CYC - 2;

    srt_op_t     last_op_q;
    logic [11:0] sect_q;
    logic [11:0] since_q;

    // ****************************************
    // Helper state
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last_op_q <= SRT_OP_NONE;
            sect_q    <= 12'h000;
            since_q   <= 12'hfff;
        end else begin
            if (req) begin
                last_op_q <= op;
            end
            // Only a start from idle names the sector that a later suspend protects
            if (req && (op == SRT_OP_ERASE || op == SRT_OP_PROG) && !busy && !esusp && !psusp) begin
                sect_q <= addr[23:12];
            end
            if (ack && last_op_q == SRT_OP_RESUME) begin
                since_q <= 12'h000;
            end else if (since_q != 12'hfff) begin
                since_q <= since_q + 12'h001;
            end
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    // ****************************************
    // Sequences
    // ****************************************
    sequence susp_run_s;
        req && op == SRT_OP_SUSPEND && busy;
    endsequence
    sequence halt_answer_s;
        (ack && !busy && (esusp || psusp)) || (nack && !busy);
    endsequence
    sequence resume_s;
        req && op == SRT_OP_RESUME;
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    param_word_a: assert property (rstn_in && $past(rstn_in) |-> param == 32'h3316_63ed)
        else $error("parameter word differs");
    suspend_halt_a: assert property (susp_run_s |-> ##[1:HALT_MAX] halt_answer_s)
        else $error("suspend not halted in time");
    resume_ok_a: assert property (resume_s ##0 (esusp || psusp) |=> ack && busy && !esusp && !psusp)
        else $error("resume while suspended not taken");
    resume_idle_a: assert property (resume_s ##0 !(esusp || psusp) |=> nack && !ack)
        else $error("resume without suspend not refused");
    resume_guard_a: assert property (req && op == SRT_OP_SUSPEND |-> since_q >= GUARD_MIN)
        else $error("suspend too soon after resume");
    erase_nest_a: assert property (esusp |-> !(req && op == SRT_OP_ERASE))
        else $error("erase issued while erase suspended");
    read_sector_a: assert property (esusp && req && op == SRT_OP_READ |-> addr[23:12] != sect_q)
        else $error("read of suspended erase sector");
    prog_nest_a: assert property (psusp |-> !(req && op == SRT_OP_PROG))
        else $error("program issued while program suspended");
    erase_page_a: assert property (psusp && req && op == SRT_OP_ERASE |-> addr[23:12] != sect_q)
        else $error("erase over suspended program page");

endmodule : srt_link_sva

// ---- verification/suspend_resume_timing_params_bench.sv ----
`timescale 1ns/1ps
`include "srt_map.svh"

module suspend_resume_timing_params_bench;
    import srt_pkg::*;

    logic      clk_in;
    logic      rstn_in;
    logic      req_valid_in;
    srt_op_t   req_op_in;
    srt_addr_t req_addr_in;
    logic      req_ready_out;
    logic      done_out;
    logic      refused_out;
    logic      op_done_out;
    srt_addr_t op_addr_out;
    int        miscompares;
    int        samples_checked;

    srt_link_if link_inst ();

    srt_dev #(.ERASE_CYCLES(2000), .PROG_CYCLES(1500), .HALT_CYCLES(1)) srt_dev_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .link(link_inst.dev),
        .op_done_out(op_done_out), .op_addr_out(op_addr_out));

    srt_host srt_host_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in), .req_op_in(req_op_in),
        .req_addr_in(req_addr_in), .req_ready_out(req_ready_out), .done_out(done_out),
        .refused_out(refused_out), .link(link_inst.host));

    srt_link_sva srt_link_sva_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .req(link_inst.req), .op(link_inst.op),
        .addr(link_inst.addr), .ack(link_inst.ack), .nack(link_inst.nack), .busy(link_inst.busy),
        .esusp(link_inst.esusp), .psusp(link_inst.psusp), .param(link_inst.param));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic timeout(input string name);
        miscompares++;
        $display("mismatch %s expected answer seen none", name);
        final_report();
    endtask : timeout

    // Presents one request and judges whether it was carried out or refused
    task automatic issue(input srt_op_t op, input srt_addr_t addr, input logic ok, input string name);
        int i;
        for (i = 0; i < 50 && req_ready_out !== 1'b1; i++) begin
            @(negedge clk_in);
        end
        if (i == 50) timeout(name);
        req_valid_in = 1'b1;
        req_op_in    = op;
        req_addr_in  = addr;
        @(negedge clk_in);
        req_valid_in = 1'b0;
        for (i = 0; i < 300 && done_out !== 1'b1 && refused_out !== 1'b1; i++) begin
            @(negedge clk_in);
        end
        if (i == 300) timeout(name);
        check(name, {31'h0000_0000, ok}, {31'h0000_0000, done_out});
        @(negedge clk_in);
    endtask : issue

    task automatic wait_op_done(input srt_addr_t addr, input string name);
        int i;
        for (i = 0; i < 3000 && op_done_out !== 1'b1; i++) begin
            @(negedge clk_in);
        end
        if (i == 3000) timeout(name);
        check(name, {8'h00, addr}, {8'h00, op_addr_out});
    endtask : wait_op_done

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic check_param_word();
        check("param word", 32'h3316_63ed, link_inst.param);
        check("erase unit", {30'h0000_0000, `SRT_UNIT_1US}, link_inst.param[30:29]);
        check("program unit", {30'h0000_0000, `SRT_UNIT_1US}, link_inst.param[19:18]);
        check("intervals", 32'h0000_0011, {24'h00_0000, link_inst.param[23:20], link_inst.param[12:9]});
    endtask : check_param_word

    task automatic erase_suspend_flow();
        issue(SRT_OP_ERASE, 24'h00_1234, 1'b1, "erase start");
        issue(SRT_OP_SUSPEND, 24'h00_0000, 1'b1, "erase suspend");
        check("erase halted", 32'h0000_0002, {29'h0, link_inst.busy, link_inst.esusp, link_inst.psusp});
        issue(SRT_OP_READ, 24'h00_1ff0, 1'b0, "read suspended sector");
        issue(SRT_OP_READ, 24'h00_5000, 1'b1, "read other sector");
        issue(SRT_OP_ERASE, 24'h00_9000, 1'b0, "nested erase");
        issue(SRT_OP_RESUME, 24'h00_0000, 1'b1, "erase resume");
        issue(SRT_OP_SUSPEND, 24'h00_0000, 1'b0, "early erase suspend");
        repeat (1300) @(negedge clk_in);
        issue(SRT_OP_SUSPEND, 24'h00_0000, 1'b1, "late erase suspend");
        issue(SRT_OP_RESUME, 24'h00_0000, 1'b1, "erase resume again");
        wait_op_done(24'h00_1234, "erase finished");
    endtask : erase_suspend_flow

    task automatic program_suspend_flow();
        // The guard from the last erase resume must run out first
        repeat (`SRT_RES2SUS_CYC) @(negedge clk_in);
        issue(SRT_OP_PROG, 24'h00_2345, 1'b1, "program start");
        issue(SRT_OP_SUSPEND, 24'h00_0000, 1'b1, "program suspend");
        check("program halted", 32'h0000_0001, {29'h0, link_inst.busy, link_inst.esusp, link_inst.psusp});
        issue(SRT_OP_PROG, 24'h00_8000, 1'b0, "nested program");
        issue(SRT_OP_ERASE, 24'h00_2000, 1'b0, "erase over page");
        issue(SRT_OP_READ, 24'h00_2000, 1'b1, "read during program suspend");
        issue(SRT_OP_RESUME, 24'h00_0000, 1'b1, "program resume");
        issue(SRT_OP_SUSPEND, 24'h00_0000, 1'b0, "early program suspend");
        repeat (1300) @(negedge clk_in);
        issue(SRT_OP_SUSPEND, 24'h00_0000, 1'b1, "late program suspend");
        issue(SRT_OP_RESUME, 24'h00_0000, 1'b1, "program resume again");
        wait_op_done(24'h00_2345, "program finished");
    endtask : program_suspend_flow

    task automatic idle_commands();
        issue(SRT_OP_RESUME, 24'h00_0000, 1'b0, "resume when idle");
        issue(SRT_OP_SUSPEND, 24'h00_0000, 1'b0, "suspend when idle");
    endtask : idle_commands

    // ****************************************
    // Clock, reset and sequence
    // ****************************************
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    initial begin
        miscompares     = 0;
        samples_checked = 0;
        rstn_in         = 1'b0;
        req_valid_in    = 1'b0;
        req_op_in       = SRT_OP_NONE;
        req_addr_in     = 24'h00_0000;
        repeat (10) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (2) @(negedge clk_in);
        check_param_word();
        idle_commands();
        erase_suspend_flow();
        program_suspend_flow();
        idle_commands();
        final_report();
    end

endmodule : suspend_resume_timing_params_bench
